// ---- pac_pkg.sv ----
package pac_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int POR_MIN_MS     = 12;
  localparam int POR_CYC        =
    (POR_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESTART_MAX_NS = 800;
  localparam int RESTART_CYC    = RESTART_MAX_NS / CLK_PERIOD_NS;
  localparam int STATUS_MIN_US  = 10;
  localparam int STATUS_CYC     =
    (STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_MIN_US    = 20;
  localparam int INIT_CYC       =
    (INIT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CD2CU_MIN_NS   = 40;
  localparam int CD2CU_CYC      =
    (CD2CU_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int USER_CLK_EDGES = 299;
  localparam int BUSY_MAX_NS    = 45;
  localparam int BUSY_CYC       = (BUSY_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  BUSY_MAX_NS / CLK_PERIOD_NS;

  // ==========================================================
  // Widths, fields, values
  localparam int DATA_W      = 8;
  localparam int FIFO_DEPTH  = 8;
  localparam int CNT_W       = 20;
  localparam int LEN_W       = 16;
  localparam int EDGE_W      = 9;
  localparam int BUSY_W      = 4;
  localparam int STATUS_BIT  = 7;
  localparam logic [7:0] HEADER_BYTE = 8'h5a;

  typedef enum logic [2:0] {
    ST_POR,
    ST_RESET,
    ST_ERROR,
    ST_WAIT_REL,
    ST_CONFIG,
    ST_DONE,
    ST_INIT,
    ST_USER
  } pac_state_e;

endpackage

// ---- pac_config_port.sv ----
`timescale 1ns/10ps
// Functional notes
// - ready_busy_n driven high outside own configuration until user mode.
// - all eight data pins stay high impedance outside own configuration.
// - only the enabled configuring device drives status on data bit 7.
// - any error pulls shared error line low and halts the whole chain.
// - initialization starts only when the shared completion line is high.
// - auto-restart releases error line within 100 us after an error.
// - identical devices with chain enable low accept one stream together.
// - restart falling pulls completion and error low within 800 ns.
// - error line released within 100 us after restart rises.
// - error line held low for 10 to 100 us after every restart.
// - write strobe rise makes ready_busy_n low briefly while byte absorbed.
// - status on bit 7 follows read strobe; host keeps 15 ns spacing.
// - data bit 7 is input for writes, output while read strobe low.
// - internal start-up reaches user mode 20 to 40 us after completion.
// - user start-up clock: wait 40 ns, then 299 of its cycles.
// - error line held low through the 12 to 100 ms power-on delay.
// - completion kept low from power-up until the next-to-last byte is in.
// - configuration pins become user I/O after configuration.
// - finished device drives chain_enable_out_n low to enable next one.
// - completion rises one byte before the last byte is sent.

// ============================================================
// Byte FIFO between the pin capture and the configuration sink
module pac_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             doWrite;
  logic             doRead;

  // Full and empty come straight from the occupancy count
  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;

  // Pointers wrap at DEPTH so non-power-of-two depths also work
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (doWrite)
      begin
        mem[wrPtr] <= inData;
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doRead)
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      if (doWrite && !doRead)
        count <= count + 1'b1;
      else if (!doWrite && doRead)
        count <= count - 1'b1;
    end
  end
endmodule

// ============================================================
// Device side of the byte-wide passive configuration port
module pac_config_port
  import pac_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              cfgRestartN,
  input  wire logic              cfgErrorNIn,
  output logic                   cfgErrorNOut,
  output logic                   cfgErrorNOe,
  input  wire logic              cfgCompleteIn,
  output logic                   cfgCompleteOut,
  output logic                   cfgCompleteOe,
  input  wire logic              chipSelLow,
  input  wire logic              chipSelHigh,
  input  wire logic              writeStrobeN,
  input  wire logic              readStrobeN,
  input  wire logic              chainEnableInN,
  output logic                   chainEnableOutN,
  output logic                   readyBusyN,
  output logic                   readyBusyOe,
  input  wire logic [DATA_W-1:0] dataIn,
  output logic      [DATA_W-1:0] dataOut,
  output logic      [DATA_W-1:0] dataOe,
  input  wire logic              userStartupClock,
  input  wire logic              userClkEn,
  input  wire logic              autoRestartEn,
  input  wire logic [LEN_W-1:0]  cfgLength,
  output logic                   userMode,
  output logic      [DATA_W-1:0] userIoIn,
  output logic      [DATA_W-1:0] cfgByte,
  output logic                   cfgByteValid,
  input  wire logic              cfgByteReady
);

  typedef struct packed {
    logic rstS1, rstS2, errS1, errS2, cmpS1, cmpS2;
    logic wsS1, wsS2, wsS3, rsS1, rsS2, ceS1, ceS2;
    logic cslS1, cslS2, cshS1, cshS2, ucS1, ucS2, ucS3;
    logic [DATA_W-1:0] dataS1;
    logic [DATA_W-1:0] dataS2;
    pac_state_e        state;
    logic [CNT_W-1:0]  cnt;
    logic [LEN_W-1:0]  byteCnt;
    logic [EDGE_W-1:0] ucCnt;
    logic [BUSY_W-1:0] busyCnt;
    logic              pushValid;
    logic [DATA_W-1:0] pushData;
    logic              errOe, cmpOe, chainOutN, rdyN, rdyOe, user;
    logic [DATA_W-1:0] dOut;
    logic [DATA_W-1:0] dOe;
    logic [DATA_W-1:0] uIo;
  } pac_regs_s;

  pac_regs_s stReg;
  pac_regs_s stNext;
  logic      fifoInReady;
  logic      wsRise;
  logic      selected;

  // ==========================================================
  // Byte buffer; a full buffer keeps the port busy
  pac_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .inValid  (stReg.pushValid),
    .inReady  (fifoInReady),
    .inData   (stReg.pushData),
    .outValid (cfgByteValid),
    .outReady (cfgByteReady),
    .outData  (cfgByte)
  );

  // Strobe edge uses second- and third-stage samples, selection second-stage only
  assign wsRise   = stReg.wsS2 && !stReg.wsS3;
  assign selected = !stReg.cslS2 && stReg.cshS2 && !stReg.ceS2;

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    stNext = stReg;
    // Two-flop synchronisers for every pin
    stNext.rstS1  = cfgRestartN;
    stNext.rstS2  = stReg.rstS1;
    stNext.errS1  = cfgErrorNIn;
    stNext.errS2  = stReg.errS1;
    stNext.cmpS1  = cfgCompleteIn;
    stNext.cmpS2  = stReg.cmpS1;
    stNext.wsS1   = writeStrobeN;
    stNext.wsS2   = stReg.wsS1;
    stNext.wsS3   = stReg.wsS2;
    stNext.rsS1   = readStrobeN;
    stNext.rsS2   = stReg.rsS1;
    stNext.ceS1   = chainEnableInN;
    stNext.ceS2   = stReg.ceS1;
    stNext.cslS1  = chipSelLow;
    stNext.cslS2  = stReg.cslS1;
    stNext.cshS1  = chipSelHigh;
    stNext.cshS2  = stReg.cshS1;
    stNext.ucS1   = userStartupClock;
    stNext.ucS2   = stReg.ucS1;
    stNext.ucS3   = stReg.ucS2;
    stNext.dataS1 = dataIn;
    stNext.dataS2 = stReg.dataS1;
    stNext.pushValid = 1'b0;
    if (stReg.cnt != '1)
      stNext.cnt = stReg.cnt + 1'b1; // Saturates, never wraps
    if (stReg.busyCnt != '0)
      stNext.busyCnt = stReg.busyCnt - 1'b1;

    case (stReg.state)
      ST_POR:
      begin
        if (stReg.cnt >= CNT_W'(POR_CYCLES - 1))
          stNext.state = ST_WAIT_REL;
      end
      ST_RESET:
      begin
        if (stReg.cnt >= CNT_W'(STATUS_CYC - 1))
          stNext.state = ST_WAIT_REL;
      end
      ST_ERROR:
      begin
        // Without auto-restart only a restart pulse leaves here
        if (autoRestartEn && stReg.cnt >= CNT_W'(STATUS_CYC - 1))
          stNext.state = ST_WAIT_REL;
      end
      ST_WAIT_REL:
      begin
        if (stReg.errS2)
        begin
          stNext.state   = ST_CONFIG;
          stNext.byteCnt = '0;
        end
      end
      ST_CONFIG:
      begin
        if (!stReg.errS2)
        begin
          stNext.state = ST_ERROR;
          stNext.cnt   = '0;
        end
        else if (stReg.byteCnt == cfgLength)
          stNext.state = ST_DONE; // After the last byte's busy cycle
        else if (wsRise && selected && stReg.busyCnt == '0 &&
                 fifoInReady && !stReg.pushValid)
        begin
          if (stReg.byteCnt == '0 && stReg.dataS2 != HEADER_BYTE)
          begin
            stNext.state = ST_ERROR;
            stNext.cnt   = '0;
          end
          else
          begin
            stNext.pushValid = 1'b1;
            stNext.pushData  = stReg.dataS2;
            stNext.byteCnt   = stReg.byteCnt + 1'b1;
            stNext.busyCnt   = BUSY_W'(BUSY_CYC);
          end
        end
      end
      ST_DONE:
      begin
        if (!stReg.errS2)
        begin
          stNext.state = ST_ERROR;
          stNext.cnt   = '0;
        end
        else if (stReg.cmpS2)
        begin
          stNext.state = ST_INIT;
          stNext.cnt   = '0;
          stNext.ucCnt = '0;
        end
      end
      ST_INIT:
      begin
        if (userClkEn)
        begin
          // User clock edges count only after the enable delay
          if (stReg.cnt >= CNT_W'(CD2CU_CYC) && stReg.ucS2 && !stReg.ucS3)
            stNext.ucCnt = stReg.ucCnt + 1'b1;
          if (stReg.ucCnt >= EDGE_W'(USER_CLK_EDGES))
            stNext.state = ST_USER;
        end
        else if (stReg.cnt >= CNT_W'(INIT_CYC - 1))
          stNext.state = ST_USER;
      end
      ST_USER:
      begin
        stNext.state = ST_USER;
      end
      default:
      begin
        stNext.state = ST_POR;
      end
    endcase

    // Restart overrides everything but power-on; timing runs from rise
    if (!stReg.rstS2 && stReg.state != ST_POR)
    begin
      stNext.state   = ST_RESET;
      stNext.cnt     = '0;
      stNext.busyCnt = '0;
    end

    // Pin drives follow the next state so they change with it
    stNext.errOe = stNext.state inside {ST_POR, ST_RESET, ST_ERROR};
    stNext.cmpOe = (stNext.state inside {ST_POR, ST_RESET, ST_ERROR,
                    ST_WAIT_REL}) ||
                   (stNext.state == ST_CONFIG &&
                    stNext.byteCnt + 1'b1 < cfgLength);
    stNext.chainOutN = !(stNext.state inside {ST_DONE, ST_INIT, ST_USER});
    stNext.rdyOe = (stNext.state != ST_USER);
    stNext.rdyN  = !(stNext.state == ST_CONFIG && !stReg.ceS2 &&
                     (stNext.busyCnt != '0 || !fifoInReady));
    stNext.user  = (stNext.state == ST_USER);
    stNext.dOe   = '0;
    stNext.dOut  = '0;
    if (stNext.state == ST_CONFIG && !stReg.rsS2 && !stReg.ceS2)
    begin
      stNext.dOe[STATUS_BIT]  = 1'b1;
      stNext.dOut[STATUS_BIT] = stNext.rdyN;
    end
    stNext.uIo = (stNext.state == ST_USER) ? stReg.dataS2 : '0;
  end

  // ==========================================================
  // State register; idle-high strobes reset high to avoid false edges
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      stReg           <= '0;
      stReg.state     <= ST_POR;
      stReg.rstS1     <= 1'b1;
      stReg.rstS2     <= 1'b1;
      stReg.wsS1      <= 1'b1;
      stReg.wsS2      <= 1'b1;
      stReg.wsS3      <= 1'b1;
      stReg.rsS1      <= 1'b1;
      stReg.rsS2      <= 1'b1;
      stReg.ceS1      <= 1'b1;
      stReg.ceS2      <= 1'b1;
      stReg.errOe     <= 1'b1;
      stReg.cmpOe     <= 1'b1;
      stReg.chainOutN <= 1'b1;
      stReg.rdyN      <= 1'b1;
      stReg.rdyOe     <= 1'b1;
    end
    else
      stReg <= stNext;
  end

  // Open-drain lines only ever pull low
  assign cfgErrorNOut    = 1'b0;
  assign cfgCompleteOut  = 1'b0;
  assign cfgErrorNOe     = stReg.errOe;
  assign cfgCompleteOe   = stReg.cmpOe;
  assign chainEnableOutN = stReg.chainOutN;
  assign readyBusyN      = stReg.rdyN;
  assign readyBusyOe     = stReg.rdyOe;
  assign dataOut         = stReg.dOut;
  assign dataOe          = stReg.dOe;
  assign userMode        = stReg.user;
  assign userIoIn        = stReg.uIo;

  // ==========================================================
  // Checks
  localparam int RST_WIN = RESTART_CYC;
  logic [CNT_W-1:0] errLowCnt;

  // Counts how long this device has been pulling the error line
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !stReg.errOe)
      errLowCnt <= '0;
    else if (errLowCnt != '1)
      errLowCnt <= errLowCnt + 1'b1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_restart_pulls_low: assert property (
    $fell(cfgRestartN) && stReg.state != ST_POR |->
      ##[1:RST_WIN] (cfgErrorNOe && cfgCompleteOe))
    else $error("restart did not pull lines low in time");
  a_error_min_low: assert property (
    $fell(cfgErrorNOe) |-> $past(errLowCnt) >= CNT_W'(STATUS_CYC - 1))
    else $error("error line released too early");
  a_idle_ready_high: assert property (
    stReg.state inside {ST_WAIT_REL, ST_DONE, ST_INIT} |->
      readyBusyN && readyBusyOe)
    else $error("ready_busy_n low outside configuration");
  a_data_quiet: assert property (
    stReg.state != ST_CONFIG |-> dataOe == '0)
    else $error("data pins driven outside configuration");
  a_poll_answer: assert property (
    stReg.state == ST_CONFIG && !stReg.rsS2 && !stReg.ceS2 &&
    stNext.state == ST_CONFIG |=> dataOe[STATUS_BIT] &&
      dataOut[STATUS_BIT] == readyBusyN)
    else $error("status not presented on bit 7");
  a_busy_on_byte: assert property (
    stReg.pushValid && fifoInReady |-> !readyBusyN ##1 readyBusyN)
    else $error("busy pulse wrong length");
  a_complete_early: assert property (
    $fell(cfgCompleteOe) && stReg.state == ST_CONFIG |->
      stReg.byteCnt + 1'b1 == cfgLength)
    else $error("completion released at wrong byte");
  a_chain_handoff: assert property (
    $fell(chainEnableOutN) |-> stReg.byteCnt == cfgLength &&
      stReg.state == ST_DONE)
    else $error("chain enable out asserted early");
  a_error_halts: assert property (
    stReg.state == ST_CONFIG && !stReg.errS2 && stReg.rstS2 |=>
      stReg.state == ST_ERROR ##1 cfgErrorNOe)
    else $error("external error did not halt configuration");
  a_init_waits: assert property (
    $rose(userMode) |-> $past(stReg.state) == ST_INIT && stReg.cmpS2)
    else $error("user mode without completion line high");
  a_init_time: assert property (
    $rose(userMode) && !userClkEn |-> $past(stReg.cnt) >= CNT_W'(INIT_CYC-1))
    else $error("user mode reached too soon");

  c_user_mode: cover property ($rose(userMode));
  c_auto_restart: cover property (
    stReg.state == ST_ERROR ##1 stReg.state == ST_WAIT_REL);
  c_poll: cover property ($rose(dataOe[STATUS_BIT]));
endmodule

// ---- pac_host_model.sv ----
`timescale 1ns/10ps
// ======================================
// Host processor on the far side
module pac_host_model
  import pac_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              readyBusyN,
  input  wire logic [DATA_W-1:0] dataOut,
  input  wire logic [DATA_W-1:0] dataOe,
  output logic      [DATA_W-1:0] dataBus,
  output logic                   writeStrobeN,
  output logic                   readStrobeN,
  output logic                   chipSelLow,
  output logic                   chipSelHigh,
  output logic                   cfgRestartN
);
  logic              hostOe;
  logic [DATA_W-1:0] hostData;
  logic [DATA_W-1:0] lastBus;

  // Idle levels at time zero
  initial
  begin
    {writeStrobeN, readStrobeN, chipSelLow, cfgRestartN} = 4'hf;
    chipSelHigh = 1'b0;
    hostOe = 1'b0;
    hostData = 8'h00;
    lastBus = 8'h00;
  end

  // Undriven lines flip each cycle so stale data never looks valid
  always_comb
  begin
    for (int i = 0; i < DATA_W; i++)
      dataBus[i] = dataOe[i] ? dataOut[i] :
                   hostOe ? hostData[i] : ~lastBus[i];
  end
  always @(posedge ref_clk)
    lastBus <= dataBus;

  // Byte write; waits for ready first, holds data past the rise
  task automatic write_byte(input logic [7:0] b, input logic sel,
                            output bit ok, output bit sawBusy);
    int n;
    n = 0;
    while (readyBusyN !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk);
      n++;
    end
    ok = (n < 100);
    sawBusy = 0;
    @(posedge ref_clk);
    #2;
    chipSelLow = 1'b0;
    chipSelHigh = sel;
    hostData = b;
    hostOe = 1'b1;
    writeStrobeN = 1'b0;
    repeat (3) @(posedge ref_clk);
    #2;
    writeStrobeN = 1'b1;
    repeat (5)
    begin
      @(posedge ref_clk);
      #2;
      if (readyBusyN === 1'b0)
        sawBusy = 1;
    end
    hostOe = 1'b0;
    chipSelLow = 1'b1;
  endtask

  // Status poll; bus released while the read strobe is low
  task automatic poll(output logic st, output logic oe7);
    @(posedge ref_clk);
    #2;
    hostOe = 1'b0;
    readStrobeN = 1'b0;
    repeat (4) @(posedge ref_clk);
    #2;
    st = dataBus[7];
    oe7 = dataOe[7];
    readStrobeN = 1'b1;
    repeat (3) @(posedge ref_clk);
    #2;
  endtask

  task automatic drive_restart(input logic v);
    @(posedge ref_clk);
    #2;
    cfgRestartN = v;
  endtask
endmodule

// ---- pac_config_port_bench.sv ----
`timescale 1ns/10ps
// ======================================
// Self-checking bench for the config port
module pac_config_port_bench
  import pac_pkg::*;
;
  localparam int POR_TEST = 220;
  logic        ref_clk = 1'b0;
  logic        sys_rst, autoRestartEn, userClkEn, userStartupClock;
  logic        chainEnableInN, cfgByteReady, cfgRestartN;
  logic        cfgErrorNOut, cfgErrorNOe, cfgCompleteOut, cfgCompleteOe;
  logic        chipSelLow, chipSelHigh, writeStrobeN, readStrobeN;
  logic        chainEnableOutN, readyBusyN, readyBusyOe;
  logic        userMode, cfgByteValid, st, oe7;
  logic        extErrN = 1'b1;
  logic [15:0] cfgLength;
  logic [7:0]  dataBus, dataOut, dataOe, userIoIn, cfgByte;
  logic [7:0]  expQ[$];
  bit          monOn, ok, busy;
  int          err_count, compares, cyc, tDone;

  always #25 ref_clk = ~ref_clk;

  pac_config_port #(.POR_CYCLES(POR_TEST)) i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cfgRestartN(cfgRestartN),
    .cfgErrorNIn(~cfgErrorNOe & extErrN), .cfgErrorNOut(cfgErrorNOut),
    .cfgErrorNOe(cfgErrorNOe), .cfgCompleteIn(~cfgCompleteOe),
    .cfgCompleteOut(cfgCompleteOut), .cfgCompleteOe(cfgCompleteOe),
    .chipSelLow(chipSelLow), .chipSelHigh(chipSelHigh),
    .writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN),
    .chainEnableInN(chainEnableInN), .chainEnableOutN(chainEnableOutN),
    .readyBusyN(readyBusyN), .readyBusyOe(readyBusyOe),
    .dataIn(dataBus), .dataOut(dataOut), .dataOe(dataOe),
    .userStartupClock(userStartupClock), .userClkEn(userClkEn),
    .autoRestartEn(autoRestartEn), .cfgLength(cfgLength),
    .userMode(userMode), .userIoIn(userIoIn), .cfgByte(cfgByte),
    .cfgByteValid(cfgByteValid), .cfgByteReady(cfgByteReady));

  pac_host_model i_host (
    .ref_clk(ref_clk), .readyBusyN(readyBusyN), .dataOut(dataOut),
    .dataOe(dataOe), .dataBus(dataBus), .writeStrobeN(writeStrobeN),
    .readStrobeN(readStrobeN), .chipSelLow(chipSelLow),
    .chipSelHigh(chipSelHigh), .cfgRestartN(cfgRestartN));

  // ======================================
  // Reporting
  task automatic complete_run();
    $display("compares %0d, err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic c, input string m);
    compares++;
    if (c !== 1'b1)
    begin
      err_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // A used-up wait ends the run at once
  task automatic bound(input int n, input int lim, input string m);
    chk(n < lim, m);
    if (n >= lim)
      complete_run();
  endtask

  // Wait until the error-line pull equals v; returns cycles waited
  task automatic wait_err(input logic v, input int lim, output int n);
    n = 0;
    while (cfgErrorNOe !== v && n < lim)
    begin
      @(posedge ref_clk);
      n++;
    end
    bound(n, lim, "error line wait ran out");
  endtask

  // Sink side compare, sampled mid-cycle to stay clear of the edge
  always @(negedge ref_clk)
    if (monOn && cfgByteValid === 1'b1 && cfgByteReady === 1'b1)
    begin
      chk(expQ.size() > 0 && cfgByte === expQ[0], "byte order");
      if (expQ.size() > 0)
        void'(expQ.pop_front());
    end

  always @(posedge ref_clk)
  begin
    cyc++;
    if (monOn && tDone == 0 && cfgCompleteOe === 1'b0)
      tDone = cyc;
  end

  // ======================================
  // Scenarios
  task automatic s_power_on();
    int n;
    chk(cfgErrorNOe === 1'b1, "error not held");
    chk(cfgCompleteOe === 1'b1, "completion not low");
    chk(dataOe === 8'h00, "data driven early");
    chk(readyBusyN === 1'b1, "ready low early");
    chk(cfgErrorNOut === 1'b0 && cfgCompleteOut === 1'b0, "lines pull high");
    wait_err(1'b0, 300, n);
    chk(n >= POR_TEST - 2, "power-on hold short");
    repeat (40) @(posedge ref_clk);
  endtask

  // Wrong first byte with auto restart on
  task automatic s_bad_header();
    int n;
    i_host.write_byte(8'h00, 1'b1, ok, busy);
    wait_err(1'b1, 20, n);
    chk(cfgCompleteOe === 1'b1, "completion not pulled");
    wait_err(1'b0, 2100, n);
    chk(n >= STATUS_CYC - 1 && n <= 2000, "error pulse width");
    repeat (40) @(posedge ref_clk);
  endtask

  // Error held without auto restart, cleared by a restart pulse
  task automatic s_restart();
    int n;
    #2;
    autoRestartEn = 1'b0;
    extErrN = 1'b0; // Another device on the line flags an error
    repeat (4) @(posedge ref_clk);
    #2;
    extErrN = 1'b1;
    chk(cfgErrorNOe === 1'b1, "external error not joined");
    repeat (2100) @(posedge ref_clk);
    chk(cfgErrorNOe === 1'b1, "error released alone");
    i_host.drive_restart(1'b0);
    n = 0;
    while (!(cfgErrorNOe === 1'b1 && cfgCompleteOe === 1'b1) && n < 16)
    begin
      @(posedge ref_clk);
      n++;
    end
    bound(n, 16, "restart response late");
    repeat (40) @(posedge ref_clk);
    i_host.drive_restart(1'b1);
    wait_err(1'b0, 2001, n);
    chk(n >= STATUS_CYC - 1, "restart pulse short");
    repeat (2000) @(posedge ref_clk);
  endtask

  // Refusals, poll, FIFO fill and drain, completion and chain out
  task automatic s_stream();
    int n;
    logic [7:0] b;
    #2;
    chainEnableInN = 1'b1;
    i_host.poll(st, oe7);
    chk(oe7 === 1'b0, "unselected chain polls");
    i_host.write_byte(HEADER_BYTE, 1'b1, ok, busy);
    chk(busy === 1'b0, "chain-disabled write taken");
    chainEnableInN = 1'b0;
    i_host.write_byte(HEADER_BYTE, 1'b0, ok, busy);
    chk(busy === 1'b0, "deselected write taken");
    i_host.poll(st, oe7);
    chk(oe7 === 1'b1 && st === 1'b1, "ready status");
    cfgByteReady = 1'b0;
    monOn = 1;
    for (int i = 0; i < 12; i++)
    begin
      if (i == 8)
      begin
        chk(readyBusyN === 1'b0, "full FIFO not busy");
        i_host.poll(st, oe7);
        chk(oe7 === 1'b1 && st === 1'b0, "busy status");
        cfgByteReady = 1'b1;
      end
      b = (i == 0) ? HEADER_BYTE : 8'h10 + 8'(i);
      expQ.push_back(b);
      i_host.write_byte(b, 1'b1, ok, busy);
      bound(ok ? 0 : 1, 1, "ready never returned");
      chk(busy === 1'b1, "no busy after write");
      if (i == 10)
        chk(cfgCompleteOe === 1'b0 && chainEnableOutN === 1'b1,
            "completion not one byte early");
    end
    chk(chainEnableOutN === 1'b0, "chain out not low");
    repeat (5) @(posedge ref_clk);
    chk(expQ.size() == 0, "bytes lost");
  endtask

  // Start-up on the internal clock, then pins hand over
  task automatic s_user();
    int n;
    n = 0;
    while (userMode !== 1'b1 && n < 1000)
    begin
      @(posedge ref_clk);
      n++;
    end
    bound(n, 1000, "user mode never reached");
    chk(cyc - tDone >= 400 && cyc - tDone <= 801, "start-up time");
    chk(dataOe === 8'h00 && readyBusyOe === 1'b0, "pins driven");
    chk(cfgErrorNOe === 1'b0, "error line in user mode");
    #2;
    i_host.hostData = 8'ha5; // Host drives a user value on the bus
    i_host.hostOe = 1'b1;
    repeat (3) @(posedge ref_clk);
    #2;
    chk(userIoIn === 8'ha5, "user input not passed");
    i_host.hostOe = 1'b0;
  endtask

  // Restart from user mode, then start-up on the user clock
  task automatic s_user_clock();
    int n;
    userClkEn = 1'b1;
    i_host.drive_restart(1'b0);
    wait_err(1'b1, 16, n);
    chk(cfgCompleteOe === 1'b1 && userMode === 1'b0, "restart ignored");
    repeat (40) @(posedge ref_clk);
    i_host.drive_restart(1'b1);
    wait_err(1'b0, 2001, n);
    repeat (2000) @(posedge ref_clk);
    s_stream();
    n = 0;
    while (userMode !== 1'b1 && n < 2000)
    begin
      @(posedge ref_clk);
      #2;
      userStartupClock = ~userStartupClock;
      n++;
    end
    bound(n, 2000, "user clock start-up hung");
    chk(n >= 2 * USER_CLK_EDGES, "user clock start-up short");
  endtask

  initial
  begin
    sys_rst = 1'b1;
    autoRestartEn = 1'b1;
    userClkEn = 1'b0;
    userStartupClock = 1'b0;
    chainEnableInN = 1'b0;
    cfgByteReady = 1'b1;
    cfgLength = 16'h000c;
    repeat (12) @(posedge ref_clk);
    #2;
    sys_rst = 1'b0;
    s_power_on();
    s_bad_header();
    s_restart();
    s_stream();
    s_user();
    s_user_clock();
    complete_run();
  end
endmodule
